// File: hw/pmicia_pkg.sv
// constants, types and register map of the pmic interrupt aggregator
// What this block does
// - fault at reset release not cleared in 2.0 ms aborts power-up, regulators off
// - supplies enabled after reset release get fault monitoring once enabled
// - with gating and gpio mode, supply-ok pin free; reset releases after a regulator
// - faults after reset release never halt the remaining power-up sequence
// - latch sets on event, readable anytime, cleared only by writing one
// - mask bit one removes that latch from the interrupt pin
// - mask bit zero drives the pin low while the latch is set
// - sense bits return the live unlatched trigger signal
// - interrupt pin is the or of all enabled status bits, active low
// - summary bits 7..0: warning, button, high v, low v, current_limit_fault, mode, two, one
// - current_limit_fault, low and high voltage summary bits combine buck and linear groups
// - summary bits 6..0 set only from unmasked second-level latches, bit 7 from the warning flag
// - clearing the second-level latch clears its summary bit automatically
// - pin stays low while any summary bit is set
// - early warning sets ahead of shutdown, lead time from 2-bit setting
// - a bypassed fault still latches and asserts the pin unless masked
package pmicia_pkg;
   localparam int CLK_MHZ = 20;
   localparam int NGRP = 10;
   // second-level group indices
   localparam int G_STAT1 = 0;
   localparam int G_THERM = 1;
   localparam int G_MODE = 2;
   localparam int G_BILIM = 3;
   localparam int G_LILIM = 4;
   localparam int G_BUV = 5;
   localparam int G_BOV = 6;
   localparam int G_LUV = 7;
   localparam int G_LOV = 8;
   localparam int G_PWRB = 9;
   // register address bases and singles
   localparam logic [7:0] A_LATCH = 8'h00;
   localparam logic [7:0] A_MASK = 8'h10;
   localparam logic [7:0] A_SENSE = 8'h20;
   localparam logic [7:0] A_ENSENSE = 8'h30;
   localparam logic [7:0] A_SUMMARY = 8'h31;
   localparam logic [7:0] MASK_RST = 8'h00;
   // summary bit positions
   localparam int S_STAT1 = 0;
   localparam int S_STAT2 = 1;
   localparam int S_MODE = 2;
   localparam int S_CURRENT_LIMIT_FAULT = 3;
   localparam int S_UV = 4;
   localparam int S_OV = 5;
   localparam int S_PWRB = 6;
   localparam int S_EWARN = 7;
   // implemented latch bits per group, others read zero
   localparam logic [NGRP-1:0][7:0] LATCH_VALID = {
      8'hFF, 8'h01, 8'h01, 8'h43, 8'h43,
      8'h01, 8'h43, 8'h43, 8'hFF, 8'hFB};
   localparam logic [NGRP-1:0][7:0] SENSE_VALID = {
      8'h81, 8'h01, 8'h01, 8'h43, 8'h43,
      8'h01, 8'h43, 8'h00, 8'hFF, 8'h03};
   // times in microseconds
   localparam int PU_WINDOW_US = 2000;
   localparam int EW_100US_US = 100;
   localparam int EW_5MS_US = 5000;
   localparam int EW_20MS_US = 20000;
   localparam int EW_50MS_US = 50000;
   localparam int TMR_W = 20;
   typedef enum logic [1:0] {
      PU_IDLE = 2'b00,
      PU_CHECK = 2'b01,
      PU_RUN = 2'b11,
      PU_ABORT = 2'b10
   } pmicia_pu_e;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pmicia_req_s;
endpackage : pmicia_pkg

// File: hw/pmicia_top.sv
// interrupt latches, masks, summary, pin and power-up fault gating
`timescale 1ns/100ps
module pmicia_top #(
   parameter int PU_WINDOW_CYC = pmicia_pkg::PU_WINDOW_US * pmicia_pkg::CLK_MHZ,
   parameter int EW_5MS_CYC = pmicia_pkg::EW_5MS_US * pmicia_pkg::CLK_MHZ,
   parameter int EW_20MS_CYC = pmicia_pkg::EW_20MS_US * pmicia_pkg::CLK_MHZ,
   parameter int EW_50MS_CYC = pmicia_pkg::EW_50MS_US * pmicia_pkg::CLK_MHZ
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire pmicia_pkg::pmicia_req_s reg_req_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [pmicia_pkg::NGRP-1:0][7:0] event_i,
   input wire logic [pmicia_pkg::NGRP-1:0][7:0] sense_i,
   input wire logic [7:0] enable_pin_i,
   input wire logic shutdown_req_i,
   input wire logic [1:0] otp_warning_lead_time_i,
   input wire logic release_due_i,
   input wire logic supply_ok_all_i,
   input wire logic [3:0] regs_on_i,
   input wire logic otp_supply_ok_gating_i,
   input wire logic supply_ok_gpio_mode_i,
   input wire logic supply_ok_gpio_val_i,
   output logic shutdown_o,
   output logic irq_out_n_o,
   output logic irq_out_n_oe_n_o,
   output logic host_reset_n_o,
   output logic host_reset_n_oe_n_o,
   output logic supply_ok_pin_o,
   output logic supply_ok_pin_oe_n_o,
   output logic seq_hold_o,
   output logic regs_off_o,
   output logic [3:0] fault_mon_en_o
);
   localparam int EW_100US_CYC = pmicia_pkg::EW_100US_US * pmicia_pkg::CLK_MHZ;

   logic [pmicia_pkg::NGRP-1:0][7:0] latch_ff;
   logic [pmicia_pkg::NGRP-1:0][7:0] mask_ff;
   logic [pmicia_pkg::NGRP-1:0] grp_act;
   logic [7:0] summary;
   logic ewarn_ff;
   logic ew_cnt_run_ff;
   logic [pmicia_pkg::TMR_W-1:0] ew_cnt_ff;
   logic [pmicia_pkg::TMR_W-1:0] ew_lead;
   logic shutdown_ff;
   logic irq_n_ff;
   logic [7:0] rdata_ff;
   pmicia_pkg::pmicia_pu_e pu_ff;
   pmicia_pkg::pmicia_pu_e nxt_pu;
   logic [pmicia_pkg::TMR_W-1:0] pu_cnt_ff;
   logic hrst_n_ff;
   logic sok_oe_n_ff;
   logic hold_ff;
   logic off_ff;
   logic [3:0] mon_ff;
   logic pu_ok;

   // per-group latch and mask registers
   generate
      for (genvar g = 0; g < pmicia_pkg::NGRP; g++) begin : g_grp
         logic lwr;
         logic mwr;
         assign lwr = reg_req_i.wr &&
            reg_req_i.addr == pmicia_pkg::A_LATCH + 8'(g);
         assign mwr = reg_req_i.wr &&
            reg_req_i.addr == pmicia_pkg::A_MASK + 8'(g);
         // set wins over write-one clear, mask ignored here
         always_ff @(posedge clock_i) begin
            if (rst_i) begin
               latch_ff[g] <= 8'h00;
            end else begin
               latch_ff[g] <= ((latch_ff[g] & ~(lwr ? reg_req_i.wdata
                  : 8'h00)) | event_i[g]) &
                  pmicia_pkg::LATCH_VALID[g];
            end
         end
         always_ff @(posedge clock_i) begin
            if (rst_i) begin
               mask_ff[g] <= pmicia_pkg::MASK_RST;
            end else if (mwr) begin
               mask_ff[g] <= reg_req_i.wdata & pmicia_pkg::LATCH_VALID[g];
            end
         end
         // group active only through unmasked latches
         assign grp_act[g] = |(latch_ff[g] & ~mask_ff[g]);
      end
   endgenerate

   // first-level summary, derived so a latch clear clears it
   always_comb begin
      summary = 8'h00;
      summary[pmicia_pkg::S_STAT1] = grp_act[pmicia_pkg::G_STAT1];
      summary[pmicia_pkg::S_STAT2] = grp_act[pmicia_pkg::G_THERM];
      summary[pmicia_pkg::S_MODE] = grp_act[pmicia_pkg::G_MODE];
      summary[pmicia_pkg::S_CURRENT_LIMIT_FAULT] = grp_act[pmicia_pkg::G_BILIM] |
         grp_act[pmicia_pkg::G_LILIM];
      summary[pmicia_pkg::S_UV] = grp_act[pmicia_pkg::G_BUV] |
         grp_act[pmicia_pkg::G_LUV];
      summary[pmicia_pkg::S_OV] = grp_act[pmicia_pkg::G_BOV] |
         grp_act[pmicia_pkg::G_LOV];
      summary[pmicia_pkg::S_PWRB] = grp_act[pmicia_pkg::G_PWRB];
      summary[pmicia_pkg::S_EWARN] = ewarn_ff;
   end

   // early warning lead time select
   always_comb begin
      case (otp_warning_lead_time_i)
         2'b00: ew_lead = pmicia_pkg::TMR_W'(EW_100US_CYC);
         2'b01: ew_lead = pmicia_pkg::TMR_W'(EW_5MS_CYC);
         2'b10: ew_lead = pmicia_pkg::TMR_W'(EW_20MS_CYC);
         default: ew_lead = pmicia_pkg::TMR_W'(EW_50MS_CYC);
      endcase
   end

   // warning flag: set on request, write one to summary bit 7 clears
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ewarn_ff <= 1'b0;
      end else if (shutdown_req_i && !ew_cnt_run_ff) begin
         ewarn_ff <= 1'b1;
      end else if (reg_req_i.wr &&
            reg_req_i.addr == pmicia_pkg::A_SUMMARY &&
            reg_req_i.wdata[pmicia_pkg::S_EWARN]) begin
         ewarn_ff <= 1'b0;
      end
   end

   // lead-time counter, shutdown pulse at its end
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ew_cnt_run_ff <= 1'b0;
         ew_cnt_ff <= '0;
         shutdown_ff <= 1'b0;
      end else begin
         shutdown_ff <= 1'b0;
         if (!ew_cnt_run_ff) begin
            ew_cnt_ff <= '0;
            ew_cnt_run_ff <= shutdown_req_i;
         end else if (ew_cnt_ff == ew_lead - 1'b1) begin
            ew_cnt_run_ff <= 1'b0;
            shutdown_ff <= 1'b1;
         end else begin
            ew_cnt_ff <= ew_cnt_ff + 1'b1;
         end
      end
   end

   // pin: or of all enabled status bits, pulled low
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         irq_n_ff <= 1'b1;
      end else begin
         irq_n_ff <= ~(|summary);
      end
   end

   // register read port, sense bits live
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_ff <= 8'h00;
      end else if (reg_req_i.addr < pmicia_pkg::A_LATCH + 8'(pmicia_pkg::NGRP)) begin
         rdata_ff <= latch_ff[reg_req_i.addr[3:0]];
      end else if (reg_req_i.addr >= pmicia_pkg::A_MASK &&
            reg_req_i.addr < pmicia_pkg::A_MASK + 8'(pmicia_pkg::NGRP)) begin
         rdata_ff <= mask_ff[reg_req_i.addr[3:0]];
      end else if (reg_req_i.addr >= pmicia_pkg::A_SENSE &&
            reg_req_i.addr < pmicia_pkg::A_SENSE + 8'(pmicia_pkg::NGRP)) begin
         rdata_ff <= sense_i[reg_req_i.addr[3:0]] &
            pmicia_pkg::SENSE_VALID[reg_req_i.addr[3:0]];
      end else if (reg_req_i.addr == pmicia_pkg::A_ENSENSE) begin
         rdata_ff <= enable_pin_i & 8'h0F;
      end else if (reg_req_i.addr == pmicia_pkg::A_SUMMARY) begin
         rdata_ff <= summary;
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   // reset may release only with supplies good and a regulator on
   assign pu_ok = supply_ok_all_i && (regs_on_i != 4'h0);

   // power-up gating state machine
   always_comb begin
      nxt_pu = pu_ff;
      case (pu_ff)
         pmicia_pkg::PU_IDLE: begin
            if (release_due_i) begin
               nxt_pu = pmicia_pkg::PU_CHECK;
            end
         end
         pmicia_pkg::PU_CHECK: begin
            if (pu_ok) begin
               nxt_pu = pmicia_pkg::PU_RUN;
            end else if (pu_cnt_ff == pmicia_pkg::TMR_W'(PU_WINDOW_CYC - 1)) begin
               nxt_pu = pmicia_pkg::PU_ABORT;
            end
         end
         pmicia_pkg::PU_RUN: nxt_pu = pmicia_pkg::PU_RUN;
         default: nxt_pu = pmicia_pkg::PU_ABORT;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pu_ff <= pmicia_pkg::PU_IDLE;
      end else begin
         pu_ff <= nxt_pu;
      end
   end

   // window timer counts while the check is open
   always_ff @(posedge clock_i) begin
      if (rst_i || pu_ff != pmicia_pkg::PU_CHECK) begin
         pu_cnt_ff <= '0;
      end else begin
         pu_cnt_ff <= pu_cnt_ff + 1'b1;
      end
   end

   // power-up outputs, all registered from next state
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         hrst_n_ff <= 1'b0;
         hold_ff <= 1'b0;
         off_ff <= 1'b0;
         mon_ff <= 4'h0;
      end else begin
         hrst_n_ff <= nxt_pu == pmicia_pkg::PU_RUN;
         hold_ff <= nxt_pu == pmicia_pkg::PU_CHECK;
         off_ff <= nxt_pu == pmicia_pkg::PU_ABORT;
         mon_ff <= (nxt_pu == pmicia_pkg::PU_RUN) ? regs_on_i : 4'h0;
      end
   end

   // supply-ok pin: free gpio under gating with gpio mode, else power-good view
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sok_oe_n_ff <= 1'b0;
      end else if (otp_supply_ok_gating_i && supply_ok_gpio_mode_i) begin
         sok_oe_n_ff <= supply_ok_gpio_val_i;
      end else begin
         sok_oe_n_ff <= supply_ok_all_i;
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign shutdown_o = shutdown_ff;
   assign irq_out_n_o = 1'b0;
   assign irq_out_n_oe_n_o = irq_n_ff;
   assign host_reset_n_o = 1'b0;
   assign host_reset_n_oe_n_o = hrst_n_ff;
   assign supply_ok_pin_o = 1'b0;
   assign supply_ok_pin_oe_n_o = sok_oe_n_ff;
   assign seq_hold_o = hold_ff;
   assign regs_off_o = off_ff;
   assign fault_mon_en_o = mon_ff;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   a_latch_sets: assert property (
      event_i[0][0] |=> latch_ff[0][0])
      else $error("status one latch missed its event");
   a_latch_holds: assert property (
      latch_ff[1][0] && !(reg_req_i.wr && reg_req_i.addr == 8'h01 &&
      reg_req_i.wdata[0]) |=> latch_ff[1][0])
      else $error("thermal latch lost without write one");
   a_masked_quiet: assert property (
      (latch_ff == '0 || (latch_ff & ~mask_ff) == '0) && !ewarn_ff
      |=> irq_out_n_oe_n_o)
      else $error("pin driven with only masked latches");
   a_unmasked_pin: assert property (
      latch_ff[9][0] && !mask_ff[9][0] |=> !irq_out_n_oe_n_o)
      else $error("unmasked latch did not drive pin");
   a_summary_current_limit_fault: assert property (
      latch_ff[4][0] && !mask_ff[4][0] |-> summary[3])
      else $error("linear current_limit_fault missing from summary");
   a_summary_clear: assert property (
      $fell(latch_ff[2][0]) && latch_ff[2] == '0 |-> !summary[2])
      else $error("mode summary not cleared");
   a_pin_summary: assert property (
      summary != 8'h00 |=> !irq_out_n_oe_n_o)
      else $error("pin released with summary set");
   // window counter never passes its end while the check is open
   a_abort_time: assert property (
      pu_ff == pmicia_pkg::PU_CHECK |->
      pu_cnt_ff < pmicia_pkg::TMR_W'(PU_WINDOW_CYC))
      else $error("power-up check window overran");
   a_release_needs_reg: assert property (
      $rose(host_reset_n_oe_n_o) |-> $past(regs_on_i) != 4'h0)
      else $error("host reset released with no regulator on");
   a_no_hold_run: assert property (
      pu_ff == pmicia_pkg::PU_RUN |-> !seq_hold_o)
      else $error("sequence held after release");
   a_warn_flag: assert property (
      shutdown_req_i && !ew_cnt_run_ff |=> ewarn_ff ##0 summary[7])
      else $error("early warning not flagged");

   c_irq_cycle: cover property (
      !irq_out_n_oe_n_o ##[1:20] irq_out_n_oe_n_o);
   c_pu_release: cover property ($rose(host_reset_n_oe_n_o));
   c_pu_abort: cover property ($rose(regs_off_o));
   c_shutdown: cover property (shutdown_o);
endmodule : pmicia_top

// File: tb/pmicia_host_model.sv
// host side model: pulled-up open-drain wires and interrupt tracking
`timescale 1ns/100ps
module pmicia_host_model (
   input wire logic clock_i,
   input wire logic irq_d_i,
   input wire logic irq_oe_n_i,
   input wire logic rst_d_i,
   input wire logic rst_oe_n_i,
   input wire logic ok_d_i,
   input wire logic ok_oe_n_i,
   output logic irq_n_o,
   output logic host_reset_n_o,
   output logic supply_ok_o,
   output logic [7:0] irq_seen_o
);
   logic irq_prev_ff = 1'b1;
   // released pins float up to the pull-up level
   assign irq_n_o = irq_oe_n_i ? 1'b1 : irq_d_i;
   assign host_reset_n_o = rst_oe_n_i ? 1'b1 : rst_d_i;
   assign supply_ok_o = ok_oe_n_i ? 1'b1 : ok_d_i;
   // host counts each falling edge it must service by a register read
   initial irq_seen_o = 8'h00;
   always @(posedge clock_i) begin
      irq_prev_ff <= irq_n_o;
      if (irq_prev_ff && !irq_n_o) begin
         irq_seen_o <= irq_seen_o + 8'h01;
      end
   end
endmodule : pmicia_host_model

// File: tb/pmicia_tb_top.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
 $display("wrong value at %0t: got %0h expected %0h", $time, a, e); end end
module pmicia_tb_top;
   localparam int EW1 = 30;
   localparam int EW2 = 40;
   localparam int EW3 = 50;
   localparam int PUW = 20;
   localparam int LEAD [4] = '{2000, EW1, EW2, EW3};
   localparam int SB [10] = '{pmicia_pkg::S_STAT1, pmicia_pkg::S_STAT2,
      pmicia_pkg::S_MODE, pmicia_pkg::S_CURRENT_LIMIT_FAULT, pmicia_pkg::S_CURRENT_LIMIT_FAULT,
      pmicia_pkg::S_UV, pmicia_pkg::S_OV, pmicia_pkg::S_UV,
      pmicia_pkg::S_OV, pmicia_pkg::S_PWRB};
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   pmicia_pkg::pmicia_req_s req = '0;
   logic [pmicia_pkg::NGRP-1:0][7:0] ev = '0;
   logic [pmicia_pkg::NGRP-1:0][7:0] sns = '0;
   logic [7:0] en_pin = 8'h00;
   logic [7:0] rdata, seen;
   logic [1:0] lead = 2'b00;
   logic [3:0] regs_on = 4'h0;
   logic [3:0] mon_en;
   logic sd_req = 1'b0, rel_due = 1'b0, ok_all = 1'b0, gating = 1'b0;
   logic gpio_mode = 1'b0, gpio_val = 1'b0;
   logic shutdown, irq_d, irq_oe_n, hr_d, hr_oe_n, ok_d, ok_oe_n;
   logic seq_hold, regs_off, irq_n, host_rst_n, ok_pin;
   int error_cnt = 0;
   int checks_done = 0;
   int n;
   // design under test with short counts
   pmicia_top #(.PU_WINDOW_CYC(PUW), .EW_5MS_CYC(EW1), .EW_20MS_CYC(EW2),
      .EW_50MS_CYC(EW3)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
      .reg_req_i(req), .reg_rdata_o(rdata), .event_i(ev), .sense_i(sns),
      .enable_pin_i(en_pin), .shutdown_req_i(sd_req),
      .otp_warning_lead_time_i(lead), .release_due_i(rel_due),
      .supply_ok_all_i(ok_all), .regs_on_i(regs_on),
      .otp_supply_ok_gating_i(gating), .supply_ok_gpio_mode_i(gpio_mode),
      .supply_ok_gpio_val_i(gpio_val), .shutdown_o(shutdown),
      .irq_out_n_o(irq_d), .irq_out_n_oe_n_o(irq_oe_n),
      .host_reset_n_o(hr_d), .host_reset_n_oe_n_o(hr_oe_n),
      .supply_ok_pin_o(ok_d), .supply_ok_pin_oe_n_o(ok_oe_n),
      .seq_hold_o(seq_hold), .regs_off_o(regs_off), .fault_mon_en_o(mon_en));
   // host on the far side of the pins
   pmicia_host_model host_u (.clock_i(clock_i), .irq_d_i(irq_d),
      .irq_oe_n_i(irq_oe_n), .rst_d_i(hr_d), .rst_oe_n_i(hr_oe_n),
      .ok_d_i(ok_d), .ok_oe_n_i(ok_oe_n), .irq_n_o(irq_n),
      .host_reset_n_o(host_rst_n), .supply_ok_o(ok_pin), .irq_seen_o(seen));
   // clock generator
   initial begin
      forever #25 clock_i = ~clock_i;
   end
   // register write: one-cycle strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      req <= '{wr: 1'b1, addr: a, wdata: d};
      @(posedge clock_i);
      req.wr <= 1'b0;
   endtask : wr
   // register read: data lands one cycle after the address
   task automatic rd(input logic [7:0] a);
      @(posedge clock_i);
      req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clock_i);
      @(negedge clock_i);
   endtask : rd
   // one-cycle event on bit zero of a group, then let the pin settle
   task automatic pulse(input int g);
      @(posedge clock_i);
      ev[g][0] <= 1'b1;
      @(posedge clock_i);
      ev[g][0] <= 1'b0;
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
   endtask : pulse
   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
   endtask : do_reset
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      test_done();
   end
   // main sequence
   initial begin
      do_reset();
      rd(pmicia_pkg::A_MASK + 8'h03);
      `CHK(rdata, pmicia_pkg::MASK_RST)
      rd(pmicia_pkg::A_SUMMARY);
      `CHK(rdata, 8'h00)
      `CHK(irq_n, 1'b1)
      pulse(pmicia_pkg::G_BILIM);
      `CHK(irq_n, 1'b0)
      wr(pmicia_pkg::A_LATCH + 8'h03, 8'h00);
      rd(pmicia_pkg::A_LATCH + 8'h03);
      `CHK(rdata, 8'h01)
      pulse(pmicia_pkg::G_BUV);
      wr(pmicia_pkg::A_LATCH + 8'h03, 8'h01);
      rd(pmicia_pkg::A_SUMMARY);
      `CHK(rdata, 8'h10)
      `CHK(irq_n, 1'b0)
      wr(pmicia_pkg::A_LATCH + 8'h05, 8'h01);
      rd(pmicia_pkg::A_SUMMARY);
      `CHK(irq_n, 1'b1)
      wr(pmicia_pkg::A_MASK + 8'h04, 8'h01);
      pulse(pmicia_pkg::G_LILIM);
      `CHK(irq_n, 1'b1)
      rd(pmicia_pkg::A_LATCH + 8'h04);
      `CHK(rdata, 8'h01)
      rd(pmicia_pkg::A_SUMMARY);
      `CHK(rdata, 8'h00)
      wr(pmicia_pkg::A_MASK + 8'h04, 8'h00);
      rd(pmicia_pkg::A_SUMMARY);
      `CHK(rdata, 8'h08)
      `CHK(irq_n, 1'b0)
      wr(pmicia_pkg::A_LATCH + 8'h04, 8'h01);
      // every group maps to its summary bit
      for (int g = 0; g < pmicia_pkg::NGRP; g++) begin
         pulse(g);
         rd(pmicia_pkg::A_SUMMARY);
         `CHK(rdata, 8'h01 << SB[g])
         `CHK(irq_n, 1'b0)
         wr(pmicia_pkg::A_LATCH + 8'(g), 8'h01);
         rd(pmicia_pkg::A_LATCH + 8'(g));
         `CHK(rdata, 8'h00)
      end
      // live sense levels, both polarities
      for (int v = 0; v < 2; v++) begin
         @(posedge clock_i);
         sns <= {pmicia_pkg::NGRP{v ? 8'h00 : 8'hFF}};
         for (int g = 0; g < pmicia_pkg::NGRP; g++) begin
            rd(pmicia_pkg::A_SENSE + 8'(g));
            `CHK(rdata, (v ? 8'h00 : pmicia_pkg::SENSE_VALID[g]))
         end
      end
      @(posedge clock_i);
      en_pin <= 8'hF5;
      rd(pmicia_pkg::A_ENSENSE);
      `CHK(rdata, 8'h05)
      rd(8'h3F);
      `CHK(rdata, 8'h00)
      // early warning for every lead-time code
      for (int m = 0; m < 4; m++) begin
         @(posedge clock_i);
         lead <= 2'(m);
         @(posedge clock_i);
         sd_req <= 1'b1;
         @(posedge clock_i);
         sd_req <= 1'b0;
         n = 0;
         while (shutdown !== 1'b1 && n < 2100) begin
            @(negedge clock_i);
            n++;
         end
         `CHK((n >= LEAD[m] - 3) && (n <= LEAD[m] + 3), 1'b1)
         `CHK(irq_n, 1'b0)
         wr(pmicia_pkg::A_SUMMARY, 8'h80);
         rd(pmicia_pkg::A_SUMMARY);
         `CHK(rdata, 8'h00)
      end
      // clean power-up, then a late fault
      @(posedge clock_i);
      {gating, gpio_mode, gpio_val, ok_all, rel_due} <= 5'h1F;
      regs_on <= 4'h1;
      repeat (5) @(negedge clock_i);
      `CHK(host_rst_n, 1'b1)
      `CHK(ok_pin, 1'b1)
      `CHK(mon_en, 4'h1)
      @(posedge clock_i);
      regs_on <= 4'h3;
      ok_all <= 1'b0;
      repeat (5) @(negedge clock_i);
      `CHK(mon_en, 4'h3)
      `CHK({seq_hold, regs_off}, 2'b00)
      // fault at release that never clears
      @(posedge clock_i);
      rel_due <= 1'b0;
      regs_on <= 4'h1;
      do_reset();
      @(posedge clock_i);
      rel_due <= 1'b1;
      repeat (10) @(negedge clock_i);
      `CHK({seq_hold, regs_off}, 2'b10)
      `CHK(mon_en, 4'h0)
      repeat (PUW) @(negedge clock_i);
      `CHK(regs_off, 1'b1)
      `CHK(host_rst_n, 1'b0)
      `CHK(seen != 8'h00, 1'b1)
      test_done();
   end
endmodule : pmicia_tb_top
